// File: sfp_map.vh
// Purpose: Named constants of the serial flash program sequencer.
// Assumes: Included by the sequencer only.
// Notes: Opcodes, protocol codes, lane widths, phases, address byte counts and sector bits.
`ifndef SFP_MAP_VH
`define SFP_MAP_VH
`define SFP_OP_WREN 8'h06
`define SFP_OP_WRDI 8'h04
`define SFP_OP_CLRFLAG 8'h50
`define SFP_OP_PP 8'h02
`define SFP_OP_DUAL_PP 8'hA2
`define SFP_OP_XDUAL_PP 8'hD2
`define SFP_OP_QUAD_PP 8'h32
`define SFP_OP_XQUAD_PP 8'h38
`define SFP_OP_PP4 8'h12
`define SFP_OP_QUAD_PP4 8'h34
`define SFP_OP_ENTER4 8'hB7
`define SFP_OP_EXIT4 8'hE9
`define SFP_OP_SUSPEND 8'h75
`define SFP_OP_RESUME 8'h7A
`define SFP_PROTO_EXT 2'h0
`define SFP_PROTO_DUAL 2'h1
`define SFP_PROTO_QUAD 2'h2
`define SFP_W1 3'h1
`define SFP_W2 3'h2
`define SFP_W4 3'h4
`define SFP_PH_OPC 2'h0
`define SFP_PH_ADDR 2'h1
`define SFP_PH_DATA 2'h2
`define SFP_PH_IGN 2'h3
`define SFP_ABYTES3 3'h3
`define SFP_ABYTES4 3'h4
`define SFP_SECT_BITS 4
`endif

// File: sfp_program_sequencer.v
// Purpose: Program command sequencer of a serial NOR flash behind its SPI pins.
// Assumes: spi_clk, spi_sel_n and serial_lanes are asynchronous and far slower than clk.
// Notes: A command is committed on the rising edge of select; the array sits outside.
//
// Behaviour
// - Opcode 50h clears erase, program and protection error flags.
// - Input uses lane zero, two lanes or four lanes per protocol, and per opcode and phase in extended protocol.
// - Select not at byte boundary: no program, no flag, latch kept.
// - Address bits are sampled on rising serial clock edges.
// - Protected target: no program, latch kept, flag bits 1 and 4 set.
// - Program timeout clears the latch and sets program failure.
// - Programming only turns ones into zeros.
// - Decode 02h, A2h and D2h as program commands.
// - Decode 32h and 38h as quad program commands.
// - Decode 12h and 34h as four-byte address program commands.
// - Write in progress is one while programming; status always visible.
// - Executed program clears the write enable latch at its end.
// - Suspend pauses and resume continues a running program.
// - Bytes past the page end wrap to the page start.
// - Overrun keeps only the last page-size bytes.
// - Short data programs only the bytes sent.
// - Four-byte commands carry a 32-bit address.
// - Address width comes from nonvolatile setting or enter/exit commands.
// - Dedicated four-byte opcodes always use four address bytes.
// - 06h sets the write enable latch; 04h clears it unless the protection error flag is set.
`timescale 1ns/10ps
`include "sfp_map.vh"
module sfp_program_sequencer #(
   parameter PAGE_BITS = 8,
   parameter ADDR_W = 32,
   parameter SECTOR_MSB = 25,
   parameter TIMEOUT_CYCLES = 1000000
) (
   input wire clk,
   input wire reset_n,
   input wire spi_clk,
   input wire spi_sel_n,
   input wire [3:0] serial_lanes,
   input wire [1:0] proto_mode,
   input wire nv_addr4,
   input wire [15:0] sector_protect,
   input wire erase_fail,
   input wire [7:0] mem_rdata,
   input wire mem_ready,
   output reg wip,
   output reg wel,
   output reg prog_err,
   output reg prot_err,
   output reg erase_err,
   output reg prog_suspended,
   output reg ctrl_ready,
   output reg addr4_mode,
   output reg [ADDR_W-1:0] mem_addr,
   output reg mem_re,
   output reg mem_we,
   output reg [7:0] mem_wdata
);
   localparam PAGE_SIZE = 1 << PAGE_BITS;
   localparam S_IDLE = 2'h0;
   localparam S_SCAN = 2'h1;
   localparam S_READ = 2'h2;
   localparam S_WRITE = 2'h3;

   reg [5:0] sync1;
   reg [5:0] sync2;
   reg clk_prev;
   reg sel_prev;
   reg [1:0] phase;
   reg [7:0] opcode;
   reg [2:0] bit_cnt;
   reg [7:0] shreg;
   reg [2:0] abytes;
   reg [31:0] addr;
   reg data_seen;
   reg [PAGE_BITS-1:0] ptr;
   reg [7:0] pbuf [0:PAGE_SIZE-1];
   reg [PAGE_SIZE-1:0] valid;
   reg [1:0] ex;
   reg [PAGE_BITS-1:0] idx;
   reg [31:0] tmo;
   reg [ADDR_W-1:0] base;
   reg [2:0] lane_w;
   reg [7:0] next_shreg;
   wire [3:0] cnt_sum;
   wire sclk_rise;
   wire sel_rise;
   wire byte_done;
   wire [2:0] need;
   wire boundary;

   function is_prog;
      input [7:0] op;
      begin
         case (op)
            `SFP_OP_PP, `SFP_OP_DUAL_PP, `SFP_OP_XDUAL_PP: is_prog = 1'b1;
            `SFP_OP_QUAD_PP, `SFP_OP_XQUAD_PP: is_prog = 1'b1;
            `SFP_OP_PP4, `SFP_OP_QUAD_PP4: is_prog = 1'b1;
            default: is_prog = 1'b0;
         endcase
      end
   endfunction

   // Only the second stage is looked at; the first may be metastable.
   always @(posedge clk) begin
      if (!reset_n) begin
         sync1 <= 6'h01;
         sync2 <= 6'h01;
         clk_prev <= 1'b0;
         sel_prev <= 1'b1;
      end else begin
         sync1 <= {serial_lanes, spi_clk, spi_sel_n};
         sync2 <= sync1;
         clk_prev <= sync2[1];
         sel_prev <= sync2[0];
      end
   end

   assign sclk_rise = sync2[1] & ~clk_prev & ~sync2[0];
   assign sel_rise = sync2[0] & ~sel_prev;

   always @* begin
      lane_w = `SFP_W1;
      if (proto_mode == `SFP_PROTO_QUAD) begin
         lane_w = `SFP_W4;
      end else if (proto_mode == `SFP_PROTO_DUAL) begin
         lane_w = `SFP_W2;
      end else if (phase == `SFP_PH_ADDR) begin
         if (opcode == `SFP_OP_XDUAL_PP) begin
            lane_w = `SFP_W2;
         end else if (opcode == `SFP_OP_XQUAD_PP) begin
            lane_w = `SFP_W4;
         end
      end else if (phase == `SFP_PH_DATA) begin
         case (opcode)
            `SFP_OP_DUAL_PP, `SFP_OP_XDUAL_PP: lane_w = `SFP_W2;
            `SFP_OP_QUAD_PP, `SFP_OP_XQUAD_PP, `SFP_OP_QUAD_PP4: lane_w = `SFP_W4;
            default: lane_w = `SFP_W1;
         endcase
      end
   end

   always @* begin
      case (lane_w)
         `SFP_W1: next_shreg = {shreg[6:0], sync2[2]};
         `SFP_W2: next_shreg = {shreg[5:0], sync2[3:2]};
         default: next_shreg = {shreg[3:0], sync2[5:2]};
      endcase
   end

   assign cnt_sum = {1'b0, bit_cnt} + {1'b0, lane_w};
   assign byte_done = sclk_rise & cnt_sum[3];
   // Dedicated four-byte opcodes ignore the mode setting.
   assign need = (addr4_mode || opcode == `SFP_OP_PP4 || opcode == `SFP_OP_QUAD_PP4) ?
      `SFP_ABYTES4 : `SFP_ABYTES3;
   assign boundary = (bit_cnt == 3'h0);

   always @(posedge clk) begin
      if (!reset_n) begin
         phase <= `SFP_PH_OPC;
         opcode <= 8'h00;
         bit_cnt <= 3'h0;
         shreg <= 8'h00;
         abytes <= 3'h0;
         addr <= 32'h0;
         data_seen <= 1'b0;
         ptr <= {PAGE_BITS{1'b0}};
         valid <= {PAGE_SIZE{1'b0}};
      end else if (sync2[0]) begin
         phase <= `SFP_PH_OPC;
         bit_cnt <= 3'h0;
         data_seen <= 1'b0;
      end else if (sclk_rise) begin
         shreg <= next_shreg;
         bit_cnt <= cnt_sum[2:0];
         if (byte_done) begin
            case (phase)
               `SFP_PH_OPC: begin
                  opcode <= next_shreg;
                  abytes <= 3'h0;
                  addr <= 32'h0;
                  // A busy array or a clear latch makes the frame a no-op.
                  if (is_prog(next_shreg) && wel && !wip) begin
                     phase <= `SFP_PH_ADDR;
                  end else begin
                     phase <= `SFP_PH_IGN;
                  end
               end
               `SFP_PH_ADDR: begin
                  addr <= {addr[23:0], next_shreg};
                  abytes <= abytes + 3'h1;
                  if (abytes + 3'h1 == need) begin
                     phase <= `SFP_PH_DATA;
                     ptr <= next_shreg[PAGE_BITS-1:0];
                     valid <= {PAGE_SIZE{1'b0}};
                  end
               end
               `SFP_PH_DATA: begin
                  pbuf[ptr] <= next_shreg;
                  valid[ptr] <= 1'b1;
                  ptr <= ptr + {{(PAGE_BITS-1){1'b0}}, 1'b1};
                  data_seen <= 1'b1;
               end
               default: phase <= `SFP_PH_IGN;
            endcase
         end
      end
   end

   wire commit_ok = sel_rise && phase != `SFP_PH_OPC && boundary;
   wire prog_go = sel_rise && phase == `SFP_PH_DATA && boundary && data_seen;
   wire protected_hit = sector_protect[addr[SECTOR_MSB -: `SFP_SECT_BITS]];
   wire clr_cmd = sel_rise && phase != `SFP_PH_OPC && opcode == `SFP_OP_CLRFLAG;
   wire timed_out = (ex != S_IDLE) && (tmo >= TIMEOUT_CYCLES - 1);
   wire last_idx = (idx == {PAGE_BITS{1'b1}});
   wire set_prot = prog_go && protected_hit;

   always @(posedge clk) begin
      if (!reset_n) begin
         wip <= 1'b0;
         wel <= 1'b0;
         prog_err <= 1'b0;
         prot_err <= 1'b0;
         erase_err <= 1'b0;
         prog_suspended <= 1'b0;
         ctrl_ready <= 1'b1;
         addr4_mode <= nv_addr4;
         mem_addr <= {ADDR_W{1'b0}};
         mem_re <= 1'b0;
         mem_we <= 1'b0;
         mem_wdata <= 8'h00;
         ex <= S_IDLE;
         idx <= {PAGE_BITS{1'b0}};
         tmo <= 32'h0;
         base <= {ADDR_W{1'b0}};
      end else begin
         ctrl_ready <= ~wip | prog_suspended;
         // A new error wins over a clear arriving in the same cycle.
         prot_err <= (prot_err & ~clr_cmd) | set_prot;
         prog_err <= (prog_err & ~clr_cmd) | set_prot | timed_out;
         erase_err <= (erase_err & ~clr_cmd) | erase_fail;
         if (commit_ok && opcode == `SFP_OP_WREN) begin
            wel <= 1'b1;
         end else if (commit_ok && opcode == `SFP_OP_WRDI && !prot_err) begin
            wel <= 1'b0;
         end
         if (commit_ok && opcode == `SFP_OP_ENTER4) begin
            addr4_mode <= 1'b1;
         end else if (commit_ok && opcode == `SFP_OP_EXIT4) begin
            addr4_mode <= 1'b0;
         end
         if (commit_ok && opcode == `SFP_OP_SUSPEND && wip) begin
            prog_suspended <= 1'b1;
         end else if (commit_ok && opcode == `SFP_OP_RESUME) begin
            prog_suspended <= 1'b0;
         end
         if (timed_out) begin
            ex <= S_IDLE;
            wip <= 1'b0;
            wel <= 1'b0;
            mem_re <= 1'b0;
            mem_we <= 1'b0;
            prog_suspended <= 1'b0;
         end else begin
            if (ex != S_IDLE && !prog_suspended) begin
               tmo <= tmo + 32'h1;
            end
            case (ex)
               S_IDLE: begin
                  if (prog_go && !protected_hit) begin
                     ex <= S_SCAN;
                     wip <= 1'b1;
                     idx <= {PAGE_BITS{1'b0}};
                     tmo <= 32'h0;
                     base <= addr[ADDR_W-1:0];
                  end
               end
               S_SCAN: begin
                  // Suspension is honoured between bytes so no write is cut short.
                  if (!prog_suspended) begin
                     if (valid[idx]) begin
                        mem_addr <= {base[ADDR_W-1:PAGE_BITS], idx};
                        mem_re <= 1'b1;
                        ex <= S_READ;
                     end else if (last_idx) begin
                        ex <= S_IDLE;
                        wip <= 1'b0;
                        wel <= 1'b0;
                     end else begin
                        idx <= idx + {{(PAGE_BITS-1){1'b0}}, 1'b1};
                     end
                  end
               end
               S_READ: begin
                  mem_re <= 1'b0;
                  if (!mem_re) begin
                     mem_wdata <= mem_rdata & pbuf[idx];
                     mem_we <= 1'b1;
                     ex <= S_WRITE;
                  end
               end
               default: begin
                  if (mem_ready) begin
                     mem_we <= 1'b0;
                     if (last_idx) begin
                        ex <= S_IDLE;
                        wip <= 1'b0;
                        // A suspend that lands on the final byte lapses with the program.
                        prog_suspended <= 1'b0;
                        wel <= 1'b0;
                     end else begin
                        idx <= idx + {{(PAGE_BITS-1){1'b0}}, 1'b1};
                        ex <= S_SCAN;
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule

// File: sfp_program_sequencer_monitor.sv
// Purpose: Port assertions of the program sequencer.
// Assumes: Synchronous active-low reset.
// Notes: The timeout bound keeps some slack for the commit latency.
`timescale 1ns/10ps
module sfp_checker #(parameter TIMEOUT_CYCLES = 1000000, parameter ADDR_W = 32) (
   input wire clk,
   input wire reset_n,
   input wire spi_sel_n,
   input wire mem_ready,
   input wire [7:0] mem_rdata,
   input wire wip,
   input wire wel,
   input wire prog_err,
   input wire prot_err,
   input wire prog_suspended,
   input wire ctrl_ready,
   input wire [ADDR_W-1:0] mem_addr,
   input wire mem_re,
   input wire mem_we,
   input wire [7:0] mem_wdata
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   int run;
   always @(posedge clk) begin
      if (!reset_n || !wip) run <= 0;
      else if (!prog_suspended) run <= run + 1;
   end
   sequence s_fetch;
      mem_re ##2 mem_we;
   endsequence
   sequence s_stall;
      mem_we && !mem_ready;
   endsequence
   AST_ONLY_CLEAR: assert property (s_fetch |-> (mem_wdata & ~$past(mem_rdata)) == 8'h00)
      else $error("write sets a cleared bit");
   AST_FETCH_WRITE: assert property (mem_re |-> ##2 mem_we)
      else $error("no write after fetch");
   // A timeout may drop a stalled write, but then write in progress falls with it.
   AST_STALL_HOLD: assert property (s_stall |=> !wip || mem_we && $stable(mem_addr) && $stable(mem_wdata))
      else $error("write dropped while stalled");
   AST_WRITE_BUSY: assert property (mem_we |-> wip)
      else $error("write while idle");
   AST_END_WEL: assert property ($fell(wip) |-> !wel)
      else $error("latch kept after program");
   AST_PROT_FLAGS: assert property ($rose(prot_err) |-> prog_err && wel && !wip)
      else $error("protection flags wrong");
   AST_READY_LAG: assert property (1'b1 |=> ctrl_ready == (!$past(wip) || $past(prog_suspended)))
      else $error("ready flag wrong");
   AST_COMMIT_SEL: assert property ($rose(wip) || $rose(wel) |-> spi_sel_n)
      else $error("commit inside frame");
   AST_SUSP_BUSY: assert property (prog_suspended |-> wip)
      else $error("suspended while idle");
   AST_TIMEOUT: assert property (run <= TIMEOUT_CYCLES + 16)
      else $error("program ran past timeout");
endmodule

// File: sfp_host.sv
// Purpose: SPI host driving select, serial clock and lanes.
// Assumes: Serial clock idles low and runs only inside frames.
// Notes: Unused lanes toggle, so a stale value never passes for data.
`timescale 1ns/10ps
module sfp_host (
   input wire clk,
   output logic spi_clk,
   output logic spi_sel_n,
   output logic [3:0] serial_lanes
);
   initial begin
      spi_clk = 1'b0;
      spi_sel_n = 1'b1;
      serial_lanes = 4'h0;
   end
   task automatic half();
      repeat (8) @(negedge clk);
   endtask
   task automatic start();
      spi_sel_n = 1'b0;
      half();
   endtask
   task automatic bits(input [7:0] b, input int n, input int w);
      logic [3:0] m;
      m = 4'((1 << w) - 1);
      for (int i = 0; i < n; i += w) begin
         serial_lanes = (~serial_lanes & ~m) | (4'(b >> (8 - w)) & m);
         b = b << w;
         half();
         spi_clk = 1'b1;
         half();
         spi_clk = 1'b0;
      end
   endtask
   task automatic stop();
      spi_sel_n = 1'b1;
      serial_lanes = ~serial_lanes;
      repeat (24) @(negedge clk);
   endtask
endmodule

// File: test_sfp_program_sequencer.sv
// Purpose: Self-checking bench of the program sequencer.
// Assumes: A 16-byte page and a short program timeout.
// Notes: Old array data is the address xor a random mask, so expectations need no memory.
`timescale 1ns/10ps
module test_sfp_program_sequencer;
   logic clk, reset_n, nv_addr4, erase_fail, mem_ready, stall, a4;
   logic [1:0] proto_mode;
   logic [15:0] sector_protect;
   logic [7:0] mem_rdata, mask;
   logic [31:0] ad;
   wire spi_clk, spi_sel_n, wip, wel, prog_err, prot_err, erase_err, prog_suspended, ctrl_ready, addr4_mode;
   wire mem_re, mem_we;
   wire [3:0] serial_lanes;
   wire [31:0] mem_addr;
   wire [7:0] mem_wdata;
   int errors, checks_done;
   logic [39:0] expq[$];
   logic [7:0] ops [7] = '{8'h02, 8'hA2, 8'hD2, 8'h32, 8'h38, 8'h12, 8'h34};
   int cnt [7] = '{3, 4, 18, 1, 16, 2, 5};
   sfp_host host (.clk(clk), .spi_clk(spi_clk), .spi_sel_n(spi_sel_n), .serial_lanes(serial_lanes));
   sfp_program_sequencer #(.PAGE_BITS(4), .TIMEOUT_CYCLES(2000)) DUT (.clk(clk), .reset_n(reset_n),
      .spi_clk(spi_clk), .spi_sel_n(spi_sel_n), .serial_lanes(serial_lanes), .proto_mode(proto_mode),
      .nv_addr4(nv_addr4), .sector_protect(sector_protect), .erase_fail(erase_fail), .mem_rdata(mem_rdata),
      .mem_ready(mem_ready), .wip(wip), .wel(wel), .prog_err(prog_err), .prot_err(prot_err),
      .erase_err(erase_err), .prog_suspended(prog_suspended), .ctrl_ready(ctrl_ready),
      .addr4_mode(addr4_mode), .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata));
   task automatic chk(input string s, input logic [39:0] e, input logic [39:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   function automatic int lw(input int x);
      return proto_mode == 2'h0 ? x : (proto_mode == 2'h1 ? 2 : 4);
   endfunction
   task automatic cmd(input [7:0] op, input int xb);
      host.start();
      host.bits(op, 8, lw(1));
      if (xb > 0) host.bits(8'h00, xb, lw(1));
      host.stop();
   endtask
   task automatic prog(input [7:0] op, input [31:0] a, input int n, input bit exe, input int xb);
      int na, wd, ix;
      logic [7:0] d;
      logic [7:0] v [16];
      bit wr [16];
      na = (op == 8'h12 || op == 8'h34 || a4) ? 4 : 3;
      wd = (op == 8'hA2 || op == 8'hD2) ? 2 : ((op == 8'h32 || op == 8'h38 || op == 8'h34) ? 4 : 1);
      host.start();
      host.bits(op, 8, lw(1));
      for (int i = na - 1; i >= 0; i--) host.bits(a[8*i+:8], 8, lw(op == 8'hD2 ? 2 : (op == 8'h38 ? 4 : 1)));
      for (int k = 0; k < n; k++) begin
         d = 8'($urandom);
         host.bits(d, 8, lw(wd));
         ix = (a[3:0] + k) % 16;
         v[ix] = d;
         wr[ix] = 1'b1;
      end
      if (xb > 0) host.bits(8'hFF, xb, lw(wd));
      for (int j = 0; j < 16 && exe; j++) if (wr[j]) expq.push_back({a[31:4], 4'(j), v[j] & ({a[7:4], 4'(j)} ^ mask)});
      host.stop();
   endtask
   task automatic wait_done();
      int t;
      t = 0;
      while (wip === 1'b1 && t < 5000) begin
         @(posedge clk);
         t++;
      end
      @(negedge clk);
      chk("wip", 0, wip);
   endtask
   always @(posedge clk) if (mem_re) mem_rdata <= mem_addr[7:0] ^ mask;
   always @(negedge clk) mem_ready <= !stall && ($urandom % 3 != 0);
   always @(posedge clk) begin
      if (mem_we === 1'b1 && mem_ready === 1'b1) begin
         if (expq.size() == 0) chk("stray write", 0, 1);
         else chk("write", expq.pop_front(), {mem_addr, mem_wdata});
      end
   end
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      tally_and_finish();
   end
   initial begin
      {reset_n, nv_addr4, erase_fail, mem_ready, stall, a4, proto_mode, sector_protect, mem_rdata} = 0;
      mask = 8'($urandom(9843));
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      repeat (6) @(negedge clk);
      chk("addr mode", 0, addr4_mode);
      prog(8'h02, 32'h40, 2, 0, 0);
      chk("ignored", 0, {wel, prog_err});
      for (int i = 0; i < 9; i++) begin
         proto_mode = i < 7 ? 2'h0 : 2'(i - 6);
         ad = (32'($urandom) & 32'h3FFFFF) | (i == 5 || i == 6 ? 32'h01000000 : 32'h0);
         if (i == 6) ad[3:0] = 4'hE;
         cmd(8'h06, 0);
         chk("wel set", 1, wel);
         prog(i < 7 ? ops[i] : 8'h02, ad, i < 7 ? cnt[i] : 3, 1, 0);
         wait_done();
         chk("wel end", 0, {wel, prog_err});
      end
      proto_mode = 2'h0;
      cmd(8'h06, 0);
      cmd(8'h04, 0);
      chk("wel off", 0, wel);
      cmd(8'h06, 0);
      prog(8'h02, 32'h80, 1, 0, 3);
      chk("partial", 4'h8, {wel, prog_err, prot_err, wip});
      sector_protect = 16'h0008;
      prog(8'h02, 32'hC00010, 2, 0, 0);
      chk("protected", 3'h7, {prot_err, prog_err, wel});
      erase_fail = 1'b1;
      @(negedge clk);
      erase_fail = 1'b0;
      chk("erase flag", 1, erase_err);
      cmd(8'h50, 3);
      chk("cleared", 4'h1, {prot_err, prog_err, erase_err, wel});
      sector_protect = 16'h0000;
      cmd(8'hB7, 0);
      chk("addr4 on", 1, addr4_mode);
      a4 = 1'b1;
      prog(8'h02, 32'h01000043, 2, 1, 0);
      wait_done();
      cmd(8'hE9, 0);
      a4 = 1'b0;
      chk("addr4 off", 0, addr4_mode);
      cmd(8'h06, 0);
      stall = 1'b1;
      prog(8'h02, 32'h105, 4, 1, 0);
      cmd(8'h75, 0);
      stall = 1'b0;
      repeat (20) @(negedge clk);
      chk("suspended", 3'h7, {prog_suspended, wip, ctrl_ready});
      cmd(8'h7A, 0);
      wait_done();
      cmd(8'h06, 0);
      stall = 1'b1;
      prog(8'h02, 32'h200, 1, 0, 0);
      wait_done();
      chk("timeout", 2'h1, {wel, prog_err});
      stall = 1'b0;
      cmd(8'h50, 0);
      chk("queue", 0, expq.size());
      cmd(8'h06, 0);
      nv_addr4 = 1'b1;
      reset_n = 1'b0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      chk("nv addr4", 1, addr4_mode);
      chk("reset flags", 7'h01, {wip, wel, prog_err, prot_err, erase_err, prog_suspended, ctrl_ready});
      tally_and_finish();
   end
endmodule
bind sfp_program_sequencer sfp_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .ADDR_W(ADDR_W)) u_chk (.clk(clk),
   .reset_n(reset_n), .spi_sel_n(spi_sel_n), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .wip(wip), .wel(wel),
   .prog_err(prog_err), .prot_err(prot_err), .prog_suspended(prog_suspended), .ctrl_ready(ctrl_ready),
   .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata));
